/* File: shared/sapc_params.svh */
/*
  Offsets, field positions, reset values and limits for the system analog PLL
  control block. Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
*/
`ifndef SAPC_PARAMS_SVH
`define SAPC_PARAMS_SVH

// Register byte offsets
`define SAPC_OFS_CTRL      4'h0
`define SAPC_OFS_STATUS    4'h4
`define SAPC_OFS_FREQ_NUM_LO 4'h8
`define SAPC_OFS_FREQ_NUM_HI 4'hC

// Control word fields
`define SAPC_CTRL_FBDIV_LSB 0
`define SAPC_CTRL_FBDIV_MSB 9
`define SAPC_CTRL_DOUBLER   16
`define SAPC_CTRL_GPIO_SEL  17

// Frequency fraction widths
`define SAPC_NUM_W 48
`define SAPC_DEN_W 16

// Feedback divider limits and reset value
`define SAPC_FBDIV_MIN   10'h06C
`define SAPC_FBDIV_MAX   10'h22C
`define SAPC_FBDIV_RESET 10'h06C

// Bit width of the control-voltage comparator code
`define SAPC_VC_W 8

`endif

/* File: shared/sapc_pkg.sv */
/*
  Types for the system analog PLL control block.
  Assumes sapc_params.svh supplies the widths.
*/
`include "sapc_params.svh"

package sapc_pkg;

  typedef enum logic [2:0] {
    SAPC_ST_BOOT = 3'h1,
    SAPC_ST_LOAD = 3'h2,
    SAPC_ST_RUN  = 3'h4
  } sapc_state_t;

  typedef enum logic [1:0] {
    SAPC_SRC_NONE = 2'h0,
    SAPC_SRC_OTP  = 2'h1,
    SAPC_SRC_EEP  = 2'h2
  } sapc_src_t;

endpackage

/* File: src/sapc_apll_control.sv */
/*
  System analog PLL control: reference path select, feedback divider,
  boot-time load from OTP or EEPROM, host rewrites over Avalon-MM, lock status.
  Assumes the boot image and control-voltage code come from outside, synchronous to i_clk.
*/
`timescale 1ns/10ps
`include "sapc_params.svh"

module sapc_apll_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Boot configuration sources
  input wire logic i_otp_enable,
  input wire logic i_otp_valid,
  input wire logic [31:0] i_otp_ctrl,
  input wire logic i_eep_enable,
  input wire logic i_eep_valid,
  input wire logic [31:0] i_eep_ctrl,
  // Analog loop interface
  input wire logic i_crystal_present,
  input wire logic [`SAPC_VC_W-1:0] i_vc_code,
  output logic o_doubler_en,
  output logic [9:0] o_fbdiv,
  output logic [`SAPC_VC_W-1:0] o_vc_lo,
  output logic [`SAPC_VC_W-1:0] o_vc_hi,
  output logic o_clocks_enable,
  // Status
  output logic o_boot_done,
  output logic o_gpio_lol,
  output logic o_gpio_lol_oe
);

  function automatic logic [9:0] clamp_div(input logic [9:0] d);
    if (d < `SAPC_FBDIV_MIN) begin
      clamp_div = `SAPC_FBDIV_MIN;
    end else if (d > `SAPC_FBDIV_MAX) begin
      clamp_div = `SAPC_FBDIV_MAX;
    end else begin
      clamp_div = d;
    end
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge_be = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge_be[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  sapc_pkg::sapc_state_t state, next_state;
  sapc_pkg::sapc_src_t src, next_src;
  logic doubler, next_doubler;
  logic gpio_sel, next_gpio_sel;
  logic [9:0] fbdiv, next_fbdiv;
  logic [`SAPC_NUM_W-1:0] freq_num, next_freq_num;
  logic [`SAPC_DEN_W-1:0] freq_den, next_freq_den;
  logic lol, next_lol;
  logic lol_sticky, next_lol_sticky;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic [31:0] ctrl_word;
  logic [31:0] boot_word;
  logic req;
  logic [`SAPC_VC_W-1:0] vc_lo, vc_hi;

  assign req = i_avs_read | i_avs_write;
  assign ctrl_word = {14'h0000, gpio_sel, doubler, 6'h00, fbdiv};
  assign boot_word = i_otp_enable && i_otp_valid ? i_otp_ctrl : i_eep_ctrl;

  // Lock window follows the divider and reference path
  always_comb begin
    vc_lo = `SAPC_VC_W'(8'h20 + {7'h00, doubler});
    vc_hi = `SAPC_VC_W'(8'hC0 - fbdiv[9:3]);
  end

  always_comb begin
    next_state = state;
    next_src = src;
    next_doubler = doubler;
    next_gpio_sel = gpio_sel;
    next_fbdiv = fbdiv;
    next_freq_num = freq_num;
    next_freq_den = freq_den;
    next_rdata = rdata;
    next_ack = 1'b0;
    unique case (state)
      sapc_pkg::SAPC_ST_BOOT: begin
        next_state = sapc_pkg::SAPC_ST_LOAD;
      end
      sapc_pkg::SAPC_ST_LOAD: begin
        // Boot load, OTP first then EEPROM
        if ((i_otp_enable && i_otp_valid) || (i_eep_enable && i_eep_valid)) begin
          next_src = (i_otp_enable && i_otp_valid) ? sapc_pkg::SAPC_SRC_OTP : sapc_pkg::SAPC_SRC_EEP;
          next_doubler = boot_word[`SAPC_CTRL_DOUBLER];
          next_gpio_sel = boot_word[`SAPC_CTRL_GPIO_SEL];
          next_fbdiv = clamp_div(boot_word[`SAPC_CTRL_FBDIV_MSB:`SAPC_CTRL_FBDIV_LSB]);
        end
        next_state = sapc_pkg::SAPC_ST_RUN;
      end
      sapc_pkg::SAPC_ST_RUN: begin
        // Host access, one wait cycle then answer
        if (req && !ack) begin
          next_ack = 1'b1;
          if (i_avs_write) begin
            unique case (i_avs_address)
              `SAPC_OFS_CTRL: begin
                next_fbdiv = clamp_div(merge_be(ctrl_word, i_avs_writedata, i_avs_byteenable)
                  [`SAPC_CTRL_FBDIV_MSB:`SAPC_CTRL_FBDIV_LSB]);
                next_doubler = merge_be(ctrl_word, i_avs_writedata, i_avs_byteenable)[`SAPC_CTRL_DOUBLER];
                next_gpio_sel = merge_be(ctrl_word, i_avs_writedata, i_avs_byteenable)[`SAPC_CTRL_GPIO_SEL];
              end
              `SAPC_OFS_FREQ_NUM_LO: begin
                next_freq_num[31:0] = merge_be(freq_num[31:0], i_avs_writedata, i_avs_byteenable);
              end
              `SAPC_OFS_FREQ_NUM_HI: begin
                {next_freq_den, next_freq_num[47:32]} =
                  merge_be({freq_den, freq_num[47:32]}, i_avs_writedata, i_avs_byteenable);
              end
              default: begin
              end
            endcase
          end else begin
            unique case (i_avs_address)
              `SAPC_OFS_CTRL: next_rdata = ctrl_word;
              `SAPC_OFS_STATUS: next_rdata = {28'h0000000, src, lol_sticky, lol};
              `SAPC_OFS_FREQ_NUM_LO: next_rdata = freq_num[31:0];
              `SAPC_OFS_FREQ_NUM_HI: next_rdata = {freq_den, freq_num[47:32]};
              default: next_rdata = 32'h00000000;
            endcase
          end
        end
      end
    endcase
  end

  // Lock comparator: locked only inside the window
  always_comb begin
    next_lol = !(state == sapc_pkg::SAPC_ST_RUN && i_vc_code >= vc_lo && i_vc_code <= vc_hi);
    next_lol_sticky = lol_sticky | lol;
    // Read of status clears the sticky bit, a new loss wins
    if (state == sapc_pkg::SAPC_ST_RUN && i_avs_read && !ack && i_avs_address == `SAPC_OFS_STATUS) begin
      next_lol_sticky = lol;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= sapc_pkg::SAPC_ST_BOOT;
      src <= sapc_pkg::SAPC_SRC_NONE;
      doubler <= 1'b0;
      gpio_sel <= 1'b0;
      fbdiv <= `SAPC_FBDIV_RESET;
      freq_num <= 48'h000000000000;
      freq_den <= 16'h0001;
      lol <= 1'b1;
      lol_sticky <= 1'b0;
      rdata <= 32'h00000000;
      ack <= 1'b0;
    end else begin
      state <= next_state;
      src <= next_src;
      doubler <= next_doubler;
      gpio_sel <= next_gpio_sel;
      fbdiv <= next_fbdiv;
      freq_num <= next_freq_num;
      freq_den <= next_freq_den;
      lol <= next_lol;
      lol_sticky <= next_lol_sticky;
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end

  assign o_avs_waitrequest = req && !ack;
  assign o_avs_readdata = rdata;
  assign o_doubler_en = doubler;
  assign o_fbdiv = fbdiv;
  assign o_vc_lo = vc_lo;
  assign o_vc_hi = vc_hi;
  assign o_clocks_enable = i_crystal_present && !lol;
  assign o_boot_done = state == sapc_pkg::SAPC_ST_RUN;
  assign o_gpio_lol = lol;
  assign o_gpio_lol_oe = gpio_sel;

  property p_fbdiv_range;
    @(posedge i_clk) disable iff (!i_resetn) fbdiv >= `SAPC_FBDIV_MIN && fbdiv <= `SAPC_FBDIV_MAX;
  endproperty
  a_fbdiv_range: assert property (p_fbdiv_range) else $error("feedback divider out of range");

  property p_boot_two;
    @(posedge i_clk) $rose(i_resetn) |-> ##2 o_boot_done;
  endproperty
  a_boot_two: assert property (p_boot_two) else $error("boot sequence not done in two cycles");

  property p_ctrl_write;
    @(posedge i_clk) disable iff (!i_resetn)
      o_boot_done && i_avs_write && !o_avs_waitrequest && i_avs_address == `SAPC_OFS_CTRL && i_avs_byteenable[2]
      |=> doubler == $past(i_avs_writedata[`SAPC_CTRL_DOUBLER]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("doubler write lost");

  property p_lock_out;
    @(posedge i_clk) disable iff (!i_resetn)
      o_boot_done && (i_vc_code < vc_lo || i_vc_code > vc_hi) |=> lol;
  endproperty
  a_lock_out: assert property (p_lock_out) else $error("lock kept outside window");

  property p_lock_in;
    @(posedge i_clk) disable iff (!i_resetn)
      o_boot_done && i_vc_code >= vc_lo && i_vc_code <= vc_hi && $stable(vc_lo) |=> !lol;
  endproperty
  a_lock_in: assert property (p_lock_in) else $error("loss reported inside window");

  property p_gpio;
    @(posedge i_clk) disable iff (!i_resetn) o_gpio_lol_oe == gpio_sel && o_gpio_lol == lol;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio does not mirror loss of lock");

  property p_sticky;
    @(posedge i_clk) disable iff (!i_resetn) lol |=> lol_sticky;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky loss not set");

  property p_wait_one;
    @(posedge i_clk) disable iff (!i_resetn) o_boot_done && req && !ack |=> !o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");

endmodule

/* File: dv/sapc_xtal_model.sv */
/*
  Crystal reference and loop control-voltage model.
  Assumes the bench sets crystal state and voltage code on i_clk.
*/
`timescale 1ns/10ps
module sapc_xtal_model (
  // Clock and controls
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [7:0] i_vc_set,
  // Loop side
  output logic o_crystal_present,
  output logic [7:0] o_vc_code
);
  initial begin
    o_crystal_present = 1'b1;
    o_vc_code = 8'hF0;
  end
  // Crystal runs unless a scenario stops it
  always @(posedge i_clk) begin
    o_crystal_present <= i_run;
    o_vc_code <= i_vc_set;
  end
endmodule

/* File: dv/testbench.sv */
/*
  Self-checking bench for the PLL control block.
  Assumes the crystal model and an Avalon-MM master driven here.
*/
`timescale 1ns/10ps
module testbench;
  logic i_clk, i_resetn, rd, wr, wt, oen, oeok, een, eeok, run, xp, dbl, lol, oe, ce, bd;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, q;
  logic [7:0] vc_set, vc, lo, hi;
  logic [9:0] fbdiv;
  int mismatches, total_checks;
  logic [3:0] cfg [3] = '{4'hB, 4'h6, 4'hF};
  logic [31:0] st [3] = '{32'hB, 32'h3, 32'h7};
  logic [31:0] fb [3] = '{32'h1F4, 32'h06C, 32'h488};

  sapc_xtal_model xtal (.i_clk(i_clk), .i_run(run), .i_vc_set(vc_set), .o_crystal_present(xp),
    .o_vc_code(vc));
  sapc_apll_control dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wt), .i_otp_enable(oen), .i_otp_valid(oeok), .i_otp_ctrl(32'h0003_0088),
    .i_eep_enable(een), .i_eep_valid(eeok), .i_eep_ctrl(32'h0000_01F4), .i_crystal_present(xp),
    .i_vc_code(vc), .o_doubler_en(dbl), .o_fbdiv(fbdiv), .o_vc_lo(lo), .o_vc_hi(hi),
    .o_clocks_enable(ce), .o_boot_done(bd), .o_gpio_lol(lol), .o_gpio_lol_oe(oe));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    // Hold the request until waitrequest is seen low at a rising edge
    do begin
      @(posedge i_clk);
    end while (wt !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(n, q, e);
  endtask

  task automatic settle;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic final_report;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    final_report();
  end

  initial begin
    i_resetn = 1'b0;
    {rd, wr, addr, wdata, be} = '0;
    {oen, oeok, een, eeok} = 4'h0;
    run = 1'b1;
    vc_set = 8'hF0;
    // OTP word: doubler on, divider 136, in the loop tuning range
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      i_resetn <= 1'b0;
      {oen, oeok, een, eeok} <= cfg[i];
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      rchk("status", 4'h4, st[i]);
      chk("ctrl", {21'h0, dbl, fbdiv}, fb[i]);
    end
    chk("boot_done", {31'h0, bd}, 32'h1);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    chk("den_reset", {16'h0, q[31:16]}, 32'h1);
    chk("window", {16'h0, lo, hi}, 32'h21AF);
    chk("gpio_oe", {31'h0, oe}, 32'h1);
    vc_set <= 8'h60;
    settle();
    chk("locked", {30'h0, lol, ce}, 32'h1);
    rchk("status", 4'h4, 32'h6);
    rchk("status", 4'h4, 32'h4);
    vc_set <= 8'hB0;
    settle();
    chk("unlocked", {30'h0, lol, ce}, 32'h2);
    run <= 1'b0;
    vc_set <= 8'h60;
    settle();
    chk("no_xtal", {31'h0, ce}, 32'h0);
    run <= 1'b1;
    bus(1'b1, 4'h0, 32'h0001_0300, 4'hF);
    chk("clamp_hi", {20'h0, oe, dbl, fbdiv}, 32'h62C);
    chk("window2", {16'h0, lo, hi}, 32'h217B);
    bus(1'b1, 4'h0, 32'h0000_0010, 4'hF);
    rchk("clamp_lo", 4'h0, 32'h6C);
    bus(1'b1, 4'h8, 32'hA5A5_5A5A, 4'hF);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'h1);
    rchk("num_lo", 4'h8, 32'hA5A5_5AFF);
    bus(1'b1, 4'hC, 32'h009E_1234, 4'hF);
    rchk("den_num_hi", 4'hC, 32'h009E_1234);
    bus(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF);
    rchk("status_ro", 4'h4, 32'h6);
    rchk("unmapped", 4'h2, 32'h0);
    final_report();
  end
endmodule
